/* rtl/rsso_pkg.sv */
// How it works
// - rotate right through carry into working register
// - rotate keeps memory, changes only carry
// - acc minus operand minus inverted carry
// - carry clear when negative, else set
// - subtract updates all six arithmetic flags
// - memory variant writes difference to memory
// - decrement memory, skip next when zero
// - skip inserts dummy cycles, two total
// - decrement into acc, memory kept, skip
package rsso_pkg;
    localparam int          RSSO_W        = 8;
    localparam logic [7:0]  RSSO_ACC_RST  = 8'h00;
    localparam logic [5:0]  RSSO_FLG_RST  = 6'h00;
    // flag vector bit positions
    localparam int          RSSO_F_C      = 0;
    localparam int          RSSO_F_AC     = 1;
    localparam int          RSSO_F_Z      = 2;
    localparam int          RSSO_F_OV     = 3;
    localparam int          RSSO_F_SC     = 4;
    localparam int          RSSO_F_CZ     = 5;
    localparam logic [1:0]  RSSO_SKIP_CYC = 2'h2;

    typedef enum logic [2:0] {
        RSSO_OP_NONE   = 3'h0,
        RSSO_OP_RRCA   = 3'h1,
        RSSO_OP_SBC_A  = 3'h2,
        RSSO_OP_SBC_M  = 3'h3,
        RSSO_OP_DZ_M   = 3'h4,
        RSSO_OP_DZ_A   = 3'h5
    } rsso_op_t;

    typedef enum logic [1:0] {
        RSSO_ST_RUN  = 2'b01,
        RSSO_ST_SKIP = 2'b10
    } rsso_state_t;
endpackage : rsso_pkg

/* rtl/rsso_sub.sv */
`timescale 1ns/1ps
module rsso_sub
    import rsso_pkg::*;
#(
    parameter int W = RSSO_W
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         c_in,
    input  wire logic         z_old,
    output logic      [W-1:0] diff,
    output logic      [5:0]   flags
);
    logic [W:0]   full;
    logic [4:0]   low;
    logic         bin;
    always_comb begin
        bin   = ~c_in;
        full  = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, bin};
        low   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        diff  = full[W-1:0];
        flags = 6'h00;
        flags[RSSO_F_C]  = ~full[W];
        flags[RSSO_F_AC] = ~low[4];
        flags[RSSO_F_Z]  = (diff == '0);
        flags[RSSO_F_OV] = (a[W-1] ^ b[W-1]) & (a[W-1] ^ diff[W-1]);
        flags[RSSO_F_SC] = flags[RSSO_F_OV] ^ diff[W-1];
        flags[RSSO_F_CZ] = flags[RSSO_F_Z] & z_old;
    end
endmodule : rsso_sub

/* rtl/rsso_core.sv */
`timescale 1ns/1ps
module rsso_core
    import rsso_pkg::*;
#(
    parameter int W = RSSO_W
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic         op_valid,
    input  wire rsso_op_t     op_code,
    input  wire logic [W-1:0] mem_rdata,
    output logic              busy,
    output logic [W-1:0]      working_register,
    output logic [5:0]        flags,
    output logic              mem_we,
    output logic [W-1:0]      mem_wdata,
    output logic              skip_next,
    output logic              dummy_cycle
);
    rsso_state_t  st_r;
    rsso_state_t  st_nxt;
    logic [1:0]   cnt_r;
    logic [1:0]   cnt_nxt;
    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;
    logic [W-1:0] wd_r;
    logic [W-1:0] wd_nxt;
    logic [5:0]   flg_r;
    logic [5:0]   flg_nxt;
    logic         we_r;
    logic         we_nxt;
    logic         skip_r;
    logic         skip_nxt;
    logic         dum_r;
    logic         dum_nxt;
    logic         busy_r;
    logic         busy_nxt;
    logic [W-1:0] diff;
    logic [W-1:0] dec;
    logic [5:0]   sflg;
    logic         go;

    // zero test shared by both decrement forms
    function automatic logic is_zero(input logic [W-1:0] v);
        return (v == '0);
    endfunction : is_zero

    rsso_sub #(.W(W)) u_sub (
        .a     (acc_r),
        .b     (mem_rdata),
        .c_in  (flg_r[RSSO_F_C]),
        .z_old (flg_r[RSSO_F_Z]),
        .diff  (diff),
        .flags (sflg)
    );

    always_comb begin
        dec      = mem_rdata - {{(W-1){1'b0}}, 1'b1};
        go       = op_valid && (st_r == RSSO_ST_RUN);
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        acc_nxt  = acc_r;
        flg_nxt  = flg_r;
        wd_nxt   = wd_r;
        we_nxt   = 1'b0;
        skip_nxt = 1'b0;
        dum_nxt  = 1'b0;
        unique case (st_r)
            RSSO_ST_RUN: begin
                if (go) begin
                    unique case (op_code)
                        RSSO_OP_RRCA: begin
                            acc_nxt = {flg_r[RSSO_F_C], mem_rdata[W-1:1]};
                            flg_nxt[RSSO_F_C] = mem_rdata[0];
                        end
                        RSSO_OP_SBC_A: begin
                            acc_nxt = diff;
                            flg_nxt = sflg;
                        end
                        RSSO_OP_SBC_M: begin
                            wd_nxt  = diff;
                            we_nxt  = 1'b1;
                            flg_nxt = sflg;
                        end
                        RSSO_OP_DZ_M: begin
                            wd_nxt   = dec;
                            we_nxt   = 1'b1;
                            skip_nxt = is_zero(dec);
                        end
                        RSSO_OP_DZ_A: begin
                            acc_nxt  = dec;
                            skip_nxt = is_zero(dec);
                        end
                        default: begin
                        end
                    endcase
                    if (skip_nxt) begin
                        st_nxt  = RSSO_ST_SKIP;
                        cnt_nxt = RSSO_SKIP_CYC;
                    end
                end
            end
            RSSO_ST_SKIP: begin
                dum_nxt = 1'b1;
                cnt_nxt = cnt_r - 2'h1;
                if (cnt_r == 2'h1) begin
                    st_nxt = RSSO_ST_RUN;
                end
            end
            default: st_nxt = RSSO_ST_RUN;
        endcase
        busy_nxt = (st_nxt == RSSO_ST_SKIP);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r   <= RSSO_ST_RUN;
            cnt_r  <= 2'h0;
            acc_r  <= RSSO_ACC_RST;
            flg_r  <= RSSO_FLG_RST;
            wd_r   <= '0;
            we_r   <= 1'b0;
            skip_r <= 1'b0;
            dum_r  <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            acc_r  <= acc_nxt;
            flg_r  <= flg_nxt;
            wd_r   <= wd_nxt;
            we_r   <= we_nxt;
            skip_r <= skip_nxt;
            dum_r  <= dum_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign busy             = busy_r;
    assign working_register = acc_r;
    assign flags            = flg_r;
    assign mem_we           = we_r;
    assign mem_wdata        = wd_r;
    assign skip_next        = skip_r;
    assign dummy_cycle      = dum_r;
endmodule : rsso_core

/* sim/rsso_core_asserts.sv */
`timescale 1ns/1ps
module rsso_core_asserts
    import rsso_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       op_valid,
    input wire rsso_op_t   op_code,
    input wire logic [7:0] mem_rdata,
    input wire logic       busy,
    input wire logic [7:0] working_register,
    input wire logic [5:0] flags,
    input wire logic       mem_we,
    input wire logic [7:0] mem_wdata,
    input wire logic       skip_next,
    input wire logic       dummy_cycle
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    wire logic tk = op_valid && !busy;
    wire logic sb = op_code == RSSO_OP_SBC_A || op_code == RSSO_OP_SBC_M;
    sequence skip_s;
        busy ##1 dummy_cycle && busy ##1 dummy_cycle && !busy ##1 !dummy_cycle;
    endsequence
    rot_acc_a: assert property (tk && op_code == RSSO_OP_RRCA |=> working_register ==
        {$past(flags[0]), $past(mem_rdata[7:1])}) else $error("rotate result wrong");
    rot_keep_a: assert property (tk && op_code == RSSO_OP_RRCA |=> !mem_we &&
        flags == {$past(flags[5:1]), $past(mem_rdata[0])}) else $error("rotate side effect");
    sbc_acc_a: assert property (tk && op_code == RSSO_OP_SBC_A |=> working_register ==
        $past(working_register) - $past(mem_rdata) - !$past(flags[0])) else $error("sbc acc");
    sbc_carry_a: assert property (tk && sb |=> flags[0] == ({1'b0, $past(working_register)} >=
        {1'b0, $past(mem_rdata)} + !$past(flags[0]))) else $error("sbc carry");
    sbc_mem_a: assert property (tk && op_code == RSSO_OP_SBC_M |=> mem_we &&
        $stable(working_register)) else $error("sbc mem");
    dec_mem_a: assert property (tk && op_code == RSSO_OP_DZ_M |=> mem_we &&
        mem_wdata == $past(mem_rdata) - 8'h01 && skip_next == ($past(mem_rdata) == 8'h01))
        else $error("dec mem");
    skip_seq_a: assert property (skip_next |-> skip_s) else $error("skip timing");
    dec_acc_a: assert property (tk && op_code == RSSO_OP_DZ_A |=> !mem_we &&
        working_register == $past(mem_rdata) - 8'h01) else $error("dec acc");
    dec_flag_a: assert property (tk && op_code inside {RSSO_OP_DZ_M, RSSO_OP_DZ_A}
        |=> $stable(flags)) else $error("dec flags");
endmodule : rsso_core_asserts
bind rsso_core rsso_core_asserts i_rsso_core_asserts (.*);

/* sim/rsso_core_bench.sv */
`timescale 1ns/1ps
module rsso_core_bench
    import rsso_pkg::*;
;
    logic       clk_sys = 0, srst = 1, op_valid = 0, busy, mem_we, skip_next, dummy_cycle;
    rsso_op_t   op_code = RSSO_OP_NONE;
    logic [7:0] mem_rdata = 8'h00, working_register, mem_wdata, acc_e = 8'h00;
    logic [5:0] flags, flg_e = 6'h00;
    int         mismatches = 0, compares = 0;
    rsso_core i_rsso_core (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid),
        .op_code(op_code), .mem_rdata(mem_rdata), .busy(busy),
        .working_register(working_register), .flags(flags), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .skip_next(skip_next), .dummy_cycle(dummy_cycle));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task do_op(input rsso_op_t op, input logic [7:0] m);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] r;
        logic       ov, we, sk;
        op_valid = 1'b1;
        op_code = op;
        mem_rdata = m;
        {we, sk, r} = {2'b00, m};
        d = {1'b0, acc_e} - {1'b0, m} - {8'h00, ~flg_e[0]};
        h = {1'b0, acc_e[3:0]} - {1'b0, m[3:0]} - {4'h0, ~flg_e[0]};
        case (op)
            RSSO_OP_RRCA: {acc_e, flg_e[0]} = {flg_e[0], m};
            RSSO_OP_SBC_A, RSSO_OP_SBC_M: begin
                r = d[7:0];
                ov = (acc_e[7] ^ m[7]) & (acc_e[7] ^ r[7]);
                flg_e = {flg_e[2] & (r == 8'h00), ov ^ r[7], ov, r == 8'h00, ~h[4], ~d[8]};
                if (op == RSSO_OP_SBC_A) acc_e = r;
                else we = 1'b1;
            end
            RSSO_OP_DZ_M: {r, we, sk} = {m - 8'h01, 1'b1, m == 8'h01};
            RSSO_OP_DZ_A: {acc_e, sk} = {m - 8'h01, m == 8'h01};
            default: ;
        endcase
        @(posedge clk_sys) #1;
        chk("acc", acc_e, working_register);
        chk("flags", {2'b00, flg_e}, {2'b00, flags});
        chk("we_skip", {6'h00, we, sk}, {6'h00, mem_we, skip_next});
        chk("pace", {6'h00, sk, 1'b0}, {6'h00, busy, dummy_cycle});
        if (we) chk("wdata", r, mem_wdata);
        if (sk) begin
            op_code = RSSO_OP_DZ_A;
            mem_rdata = 8'h01;
            @(posedge clk_sys) #1;
            chk("refused", acc_e, working_register);
            chk("pace2", 8'h03, {6'h00, busy, dummy_cycle});
            @(posedge clk_sys) #1;
            chk("refused3", acc_e, working_register);
            chk("pace3", 8'h01, {6'h00, busy, dummy_cycle});
        end
    endtask : do_op
    task give_verdict;
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        void'($urandom(21));
        repeat (20) @(posedge clk_sys);
        #1 srst = 1'b0;
        do_op(RSSO_OP_DZ_M, 8'h01);
        do_op(RSSO_OP_DZ_A, 8'h00);
        do_op(RSSO_OP_SBC_A, 8'h7f);
        do_op(RSSO_OP_SBC_M, 8'hff);
        do_op(RSSO_OP_RRCA, 8'h01);
        repeat (600) do_op(rsso_op_t'($urandom_range(5)), 8'($urandom));
        give_verdict();
    end
endmodule : rsso_core_bench
